// file: logic/brsc_pkg.sv
// constants, types and rule summary for the bridge reset and strap control block
// ============================================================================
// Contract
// R01 - pci reset clears all; holds local reset out
// R02 - local reset input resets most internal state
// R03 - in reset on pci, local or unhealthy
// R04 - software bit one asserts local reset out
// R05 - software bit zero negates local reset out
// R06 - local reset input clears software bit, negates
// R07 - pci reset clears bit; output held until release
// R08 - software bit never resets internal logic
// R09 - board should not loop output to input
// R10 - no pci decode during local reset input
// R11 - claimed cycle drops devsel, no trdy/stop
// R12 - registers reachable without local bus clock
// R13 - reset inputs asynchronous to clocks
// R14 - ending software reset needs running clocks
// R15 - unlocked clock: no strobes from local side
// R16 - bus master strap sampled during reset
// R17 - four master/slave modes from two pins
// R18 - eeprom strap or serial data starts load
// R19 - access disable strap retries pci accesses
// R20 - arbiter strap enables internal pci arbiter
// R21 - test mode pins latched at each reset
// R22 - test mode: nand tree on serial clock
// R23 - unhealthy: internal reset, indicator low, tristate
// R24 - power state bit: reset out 512..1024 clocks
// R25 - resets synchronised; straps caught before release
`default_nettype none

package brsc_pkg;

	// ========================================================================
	// clock and timing
	localparam int unsigned CLK_PERIOD_NS  = 10;
	localparam int unsigned PSC_MIN_CLKS   = 512;
	localparam int unsigned PSC_MAX_CLKS   = 1024;
	localparam int unsigned PSC_HOLD_CLKS  = (PSC_MIN_CLKS + PSC_MAX_CLKS) / 2;
	localparam int unsigned PSC_CNT_W      = 11;
	localparam int unsigned NAND_W         = 8;

	// ========================================================================
	// register map, byte addresses on a 32-bit wishbone
	localparam logic [7:0] MISC_CTRL_ADDR  = 8'h00;
	localparam logic [7:0] MISC_CTRL2_ADDR = 8'h04;
	localparam logic [7:0] STATUS_ADDR     = 8'h08;

	// misc_control_reg fields
	localparam int unsigned SOFTWARE_RESET_BIT_BIT     = 0;
	localparam int unsigned PSC_RST_BIT    = 1;
	// misc_control_reg_two fields
	localparam int unsigned PCI_ACCESS_DISABLE_BIT    = 0;
	localparam int unsigned BME_BIT        = 1;
	// status fields
	localparam int unsigned ST_MODE_LSB    = 0;
	localparam int unsigned ST_EEPROM_BIT  = 2;
	localparam int unsigned ST_ARB_BIT     = 3;
	localparam int unsigned ST_TMODE_LSB   = 4;
	localparam int unsigned ST_INRST_BIT   = 6;
	localparam int unsigned ST_LRO_BIT     = 7;
	localparam int unsigned ST_UNHEALTH_BIT = 8;

	// ========================================================================
	// reset values and encodings
	localparam logic [1:0] TEST_MODE_NORMAL = 2'h0;
	localparam logic [2:0] SYNC_RESET_VAL  = 3'h7;
	localparam logic [31:0] DATA_ZERO      = 32'h0000_0000;

	// strap values caught while the block is held in reset
	typedef struct packed {
		logic [1:0] ms_mode;
		logic       eeprom_load;
		logic       arbiter_en;
		logic       pci_access_disable;
		logic       bus_master_en;
		logic [1:0] test_mode;
	} brsc_strap_t;

	localparam brsc_strap_t STRAP_RESET_VAL = '{
		ms_mode:       2'h0,
		eeprom_load:   1'b0,
		arbiter_en:    1'b0,
		pci_access_disable:       1'b0,
		bus_master_en: 1'b0,
		test_mode:     2'h0
	};

endpackage : brsc_pkg

`default_nettype wire

// file: logic/brsc_top.sv
// reset sequencing, software reset, strap capture and pci target gating
`timescale 1ns/1ns
`default_nettype none

module brsc_top (
	// clock, reset, enable
	input  wire logic                           ref_clk_in,
	input  wire logic                           rst_in,
	input  wire logic                           ce_in,
	// reset and health pins
	input  wire logic                           pci_reset_n_in,
	input  wire logic                           local_reset_in_n_in,
	input  wire logic                           backend_healthy_n_in,
	output logic                                local_reset_out_n_out,
	output logic                                local_reset_out_n_oe_out,
	output logic                                hot_swap_indicator_out,
	output logic                                hot_swap_indicator_oe_out,
	output logic                                outputs_enable_out,
	// strap pins
	input  wire logic                           bus_master_strap_in,
	input  wire logic                           burst_in_progress_pin_in,
	input  wire logic                           size_bit_one_pin_in,
	input  wire logic                           eeprom_enable_strap_in,
	input  wire logic                           serial_data_in,
	input  wire logic                           pci_access_disable_strap_in,
	input  wire logic                           arbiter_enable_strap_in,
	input  wire logic [1:0]                     test_mode_pins_in,
	// test mode and serial clock
	input  wire logic [brsc_pkg::NAND_W-1:0]    nand_tree_in,
	input  wire logic                           serial_clock_in,
	input  wire logic                           serial_clock_oe_in,
	output logic                                serial_clock_out,
	output logic                                serial_clock_oe_out,
	// configuration results
	output logic                                device_in_reset_out,
	output logic                                bus_master_enable_bit_out,
	output logic [1:0]                          ms_mode_out,
	output logic                                arbiter_enable_out,
	output logic                                eeprom_load_start_out,
	output logic                                pci_access_disable_out,
	// pci target gating
	input  wire logic                           pci_claim_in,
	input  wire logic                           pci_ready_in,
	output logic                                devsel_out,
	output logic                                trdy_out,
	output logic                                stop_out,
	// wishbone slave
	input  wire logic                           wb_cyc_in,
	input  wire logic                           wb_stb_in,
	input  wire logic                           wb_we_in,
	input  wire logic [7:0]                     wb_adr_in,
	input  wire logic [3:0]                     wb_sel_in,
	input  wire logic [31:0]                    wb_dat_in,
	output logic [31:0]                         wb_dat_out,
	output logic                                wb_ack_out
);

	// ========================================================================
	// reset input synchronisers
	// bit 0 pci reset, bit 1 local reset, bit 2 back end unhealthy; all active high
	logic [2:0]                  sync1_r;
	logic [2:0]                  sync2_r;
	logic                        pci_rst_s;
	logic                        local_rst_s;
	logic                        unhealthy_s;
	logic                        local_rst_any;
	logic                        psc_busy;
	logic                        dev_in_reset;
	logic                        dev_in_reset_d_r;
	logic                        pci_hold;
	logic                        lro_assert;

	// the pins move at any time, so they reach logic through two flops; only target gating also sees the raw local reset pin
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			sync1_r <= brsc_pkg::SYNC_RESET_VAL;
			sync2_r <= brsc_pkg::SYNC_RESET_VAL;
		end else if (ce_in) begin
			sync1_r <= {backend_healthy_n_in, ~local_reset_in_n_in, ~pci_reset_n_in}; // [R13]
			sync2_r <= sync1_r; // [R25]
		end
	end

	assign pci_rst_s     = sync2_r[0];
	assign local_rst_s   = sync2_r[1];
	assign unhealthy_s   = sync2_r[2];
	// target gating also looks at the raw pin so a claim is dropped at once
	assign local_rst_any = local_rst_s | ~local_reset_in_n_in;

	// software reset bit is deliberately absent here
	assign dev_in_reset  = pci_rst_s | local_rst_s | unhealthy_s | psc_busy; // [R03] [R08]
	assign device_in_reset_out = dev_in_reset;

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			dev_in_reset_d_r <= 1'b1;
		end else if (ce_in) begin
			dev_in_reset_d_r <= dev_in_reset;
		end
	end

	// ========================================================================
	// wishbone slave
	logic                        ack_r;
	logic [31:0]                 dat_r;
	logic                        bus_req;
	logic                        wr_commit;
	logic                        wr_misc;
	logic                        wr_misc2;
	logic [31:0]                 rdata;
	logic                        software_reset_bit_r;
	logic [brsc_pkg::PSC_CNT_W-1:0] psc_cnt_r;
	brsc_pkg::brsc_strap_t       strap_r;
	logic                        pci_access_disable_r;
	logic                        bme_r;

	assign bus_req   = wb_cyc_in & wb_stb_in;
	// a write lands on the edge where the master sees ack
	assign wr_commit = bus_req & wb_we_in & ack_r & wb_sel_in[0];
	assign wr_misc   = wr_commit & (wb_adr_in == brsc_pkg::MISC_CTRL_ADDR);
	assign wr_misc2  = wr_commit & (wb_adr_in == brsc_pkg::MISC_CTRL2_ADDR);

	always_comb begin
		rdata = brsc_pkg::DATA_ZERO;
		case (wb_adr_in)
			brsc_pkg::MISC_CTRL_ADDR: begin
				rdata[brsc_pkg::SOFTWARE_RESET_BIT_BIT]  = software_reset_bit_r;
				rdata[brsc_pkg::PSC_RST_BIT] = psc_busy;
			end
			brsc_pkg::MISC_CTRL2_ADDR: begin
				rdata[brsc_pkg::PCI_ACCESS_DISABLE_BIT] = pci_access_disable_r;
				rdata[brsc_pkg::BME_BIT]     = bme_r;
			end
			brsc_pkg::STATUS_ADDR: begin
				rdata[brsc_pkg::ST_MODE_LSB +: 2]  = strap_r.ms_mode;
				rdata[brsc_pkg::ST_EEPROM_BIT]     = strap_r.eeprom_load;
				rdata[brsc_pkg::ST_ARB_BIT]        = strap_r.arbiter_en;
				rdata[brsc_pkg::ST_TMODE_LSB +: 2] = strap_r.test_mode;
				rdata[brsc_pkg::ST_INRST_BIT]      = dev_in_reset;
				rdata[brsc_pkg::ST_LRO_BIT]        = lro_assert;
				rdata[brsc_pkg::ST_UNHEALTH_BIT]   = unhealthy_s;
			end
			default: begin
				rdata = brsc_pkg::DATA_ZERO;
			end
		endcase
	end

	// one wait state; unmapped addresses answer with zero and drop writes.
	// runs on the reference clock only, so the local bus clock is not needed
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			ack_r <= 1'b0;
			dat_r <= brsc_pkg::DATA_ZERO;
		end else if (ce_in) begin
			ack_r <= bus_req & ~ack_r; // [R12]
			if (bus_req & ~ack_r) begin
				dat_r <= rdata;
			end
		end
	end

	assign wb_ack_out = ack_r;
	assign wb_dat_out = dat_r;

	// ========================================================================
	// software reset bit
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			software_reset_bit_r <= 1'b0;
		end else if (ce_in) begin
			if (pci_rst_s | unhealthy_s) begin
				software_reset_bit_r <= 1'b0; // [R01] [R07]
			end else if (local_rst_s) begin
				software_reset_bit_r <= 1'b0; // [R06] [R02]
			end else if (wr_misc) begin
				software_reset_bit_r <= wb_dat_in[brsc_pkg::SOFTWARE_RESET_BIT_BIT]; // [R04] [R05] [R14]
			end
		end
	end

	// ========================================================================
	// power state change reset timer
	// not cleared by the internal reset it causes, or it would cut itself short
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			psc_cnt_r <= '0;
		end else if (ce_in) begin
			if (psc_busy) begin
				psc_cnt_r <= psc_cnt_r - 1'b1; // [R24]
			end else if (wr_misc & wb_dat_in[brsc_pkg::PSC_RST_BIT]) begin
				psc_cnt_r <= brsc_pkg::PSC_CNT_W'(brsc_pkg::PSC_HOLD_CLKS); // [R24]
			end
		end
	end

	assign psc_busy = (psc_cnt_r != '0);

	// ========================================================================
	// local reset output
	assign pci_hold   = pci_rst_s & ~unhealthy_s; // [R01] [R07]
	assign lro_assert = pci_hold | software_reset_bit_r | psc_busy; // [R04] [R24]
	assign local_reset_out_n_out    = ~lro_assert; // [R05] [R06]

	// ========================================================================
	// strap capture
	// sampled every cycle in reset, so the last cycle before release wins
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			strap_r <= brsc_pkg::STRAP_RESET_VAL;
		end else if (ce_in && dev_in_reset) begin
			strap_r.bus_master_en <= bus_master_strap_in; // [R16] [R25]
			strap_r.ms_mode       <= {burst_in_progress_pin_in, size_bit_one_pin_in}; // [R17]
			strap_r.eeprom_load   <= eeprom_enable_strap_in | serial_data_in; // [R18]
			strap_r.pci_access_disable       <= pci_access_disable_strap_in; // [R19]
			strap_r.arbiter_en    <= arbiter_enable_strap_in; // [R20]
			strap_r.test_mode     <= test_mode_pins_in; // [R21]
		end
	end

	// software-writable bits that take the strap as their reset value
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			pci_access_disable_r <= 1'b0;
			bme_r     <= 1'b0;
		end else if (ce_in) begin
			if (dev_in_reset) begin
				pci_access_disable_r <= pci_access_disable_strap_in; // [R19]
				bme_r     <= bus_master_strap_in; // [R16]
			end else if (wr_misc2) begin
				pci_access_disable_r <= wb_dat_in[brsc_pkg::PCI_ACCESS_DISABLE_BIT]; // [R19]
				bme_r     <= wb_dat_in[brsc_pkg::BME_BIT];
			end
		end
	end

	assign bus_master_enable_bit_out = bme_r;
	assign ms_mode_out               = strap_r.ms_mode;
	assign arbiter_enable_out        = strap_r.arbiter_en & ~dev_in_reset; // [R20]
	assign pci_access_disable_out    = pci_access_disable_r;

	// eeprom download request: one pulse on the cycle after release
	logic                        eeprom_start_r;

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			eeprom_start_r <= 1'b0;
		end else if (ce_in) begin
			eeprom_start_r <= dev_in_reset_d_r & ~dev_in_reset & strap_r.eeprom_load; // [R18]
		end
	end

	assign eeprom_load_start_out = eeprom_start_r;

	// ========================================================================
	// test mode and pin enables
	logic                        test_active;
	logic                        nand_r;

	assign test_active = (strap_r.test_mode != brsc_pkg::TEST_MODE_NORMAL); // [R21]

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			nand_r <= 1'b0;
		end else if (ce_in) begin
			nand_r <= ~(&nand_tree_in); // [R22]
		end
	end

	assign serial_clock_out    = test_active ? nand_r : serial_clock_in; // [R22]
	assign serial_clock_oe_out = ~unhealthy_s & (test_active | serial_clock_oe_in);
	assign outputs_enable_out  = ~unhealthy_s & ~test_active; // [R22] [R23]
	assign local_reset_out_n_oe_out  = outputs_enable_out;
	// indicator pulled low while the back end is down, otherwise released
	assign hot_swap_indicator_out    = 1'b0; // [R23]
	assign hot_swap_indicator_oe_out = unhealthy_s; // [R23]

	// ========================================================================
	// pci target gating
	// a local reset stops decode and kills an existing claim without trdy or stop
	assign devsel_out = pci_claim_in & ~local_rst_any & ~unhealthy_s; // [R10] [R11]
	assign trdy_out   = devsel_out & pci_ready_in & ~pci_access_disable_r; // [R11]
	assign stop_out   = devsel_out & pci_access_disable_r; // [R19] [R11]

	// ========================================================================
	// assertions
	logic [brsc_pkg::PSC_CNT_W-1:0] lro_len_r;

	// counts how long the timer has held the output low
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			lro_len_r <= '0;
		end else if (ce_in) begin
			lro_len_r <= psc_busy ? lro_len_r + 1'b1 : '0;
		end
	end

	sequence s_sw_write_one;
		ce_in && wr_misc && wb_dat_in[0] && !dev_in_reset;
	endsequence

	sequence s_reset_out_low;
		!local_reset_out_n_out;
	endsequence

	property p_sw_set;
		@(posedge ref_clk_in) disable iff (rst_in)
		s_sw_write_one ##1 !dev_in_reset |-> s_reset_out_low;
	endproperty
	a_sw_set: assert property (p_sw_set) else $error("software reset did not drive output"); // [R04]

	property p_sw_clear;
		@(posedge ref_clk_in) disable iff (rst_in)
		(ce_in && wr_misc && !wb_dat_in[0] && !wb_dat_in[1] && !pci_hold && !psc_busy
			&& !dev_in_reset) |=> local_reset_out_n_out;
	endproperty
	a_sw_clear: assert property (p_sw_clear) else $error("output not negated after clear"); // [R05]

	property p_local_clears;
		@(posedge ref_clk_in) disable iff (rst_in)
		(ce_in && local_rst_s && !pci_rst_s && !psc_busy) |=> !software_reset_bit_r && local_reset_out_n_out;
	endproperty
	a_local_clears: assert property (p_local_clears) else $error("local reset left output low"); // [R06]

	property p_pci_holds;
		@(posedge ref_clk_in) disable iff (rst_in)
		(ce_in && pci_rst_s && !unhealthy_s) |-> !local_reset_out_n_out ##1 !software_reset_bit_r;
	endproperty
	a_pci_holds: assert property (p_pci_holds) else $error("pci reset did not hold output"); // [R07]

	property p_psc_len;
		@(posedge ref_clk_in) disable iff (rst_in)
		(ce_in && $fell(psc_busy)) |-> ($past(lro_len_r) + 1'b1 >= 11'd512)
			&& ($past(lro_len_r) + 1'b1 <= 11'd1024);
	endproperty
	a_psc_len: assert property (p_psc_len) else $error("power state reset length off"); // [R24]

	property p_psc_low;
		@(posedge ref_clk_in) disable iff (rst_in)
		$rose(psc_busy) |-> (!local_reset_out_n_out && dev_in_reset) [*8];
	endproperty
	a_psc_low: assert property (p_psc_low) else $error("power state reset dropped early"); // [R24]

	property p_no_decode;
		@(posedge ref_clk_in) disable iff (rst_in)
		local_rst_any |-> !devsel_out && !trdy_out && !stop_out;
	endproperty
	a_no_decode: assert property (p_no_decode) else $error("target active in local reset"); // [R10]

	property p_retry;
		@(posedge ref_clk_in) disable iff (rst_in)
		(pci_access_disable_r && pci_claim_in && !local_rst_any && !unhealthy_s) |-> stop_out && !trdy_out;
	endproperty
	a_retry: assert property (p_retry) else $error("access not retried while disabled"); // [R19]

	property p_bm_strap;
		@(posedge ref_clk_in) disable iff (rst_in)
		(ce_in && dev_in_reset && !wr_misc2) |=> (bme_r == $past(bus_master_strap_in));
	endproperty
	a_bm_strap: assert property (p_bm_strap) else $error("bus master strap not sampled"); // [R16]

	property p_unhealthy;
		@(posedge ref_clk_in) disable iff (rst_in)
		unhealthy_s |-> hot_swap_indicator_oe_out && !hot_swap_indicator_out
			&& !outputs_enable_out && dev_in_reset;
	endproperty
	a_unhealthy: assert property (p_unhealthy) else $error("unhealthy state not applied"); // [R23]

	property p_eeprom;
		@(posedge ref_clk_in) disable iff (rst_in)
		(ce_in && dev_in_reset_d_r && !dev_in_reset && strap_r.eeprom_load)
			|=> eeprom_load_start_out ##1 !eeprom_load_start_out;
	endproperty
	a_eeprom: assert property (p_eeprom) else $error("eeprom load not requested once"); // [R18]

	property p_test_mode;
		@(posedge ref_clk_in) disable iff (rst_in)
		test_active |-> !outputs_enable_out && (serial_clock_out == nand_r);
	endproperty
	a_test_mode: assert property (p_test_mode) else $error("test mode pins wrong"); // [R22]

	property p_sw_internal;
		@(posedge ref_clk_in) disable iff (rst_in)
		(software_reset_bit_r && !pci_rst_s && !local_rst_s && !unhealthy_s && !psc_busy) |-> !dev_in_reset;
	endproperty
	a_sw_internal: assert property (p_sw_internal) else $error("software reset hit internals"); // [R08]

endmodule : brsc_top

`default_nettype wire

// file: tb/brsc_partner.sv
// far-side model: pci host reset, back-end health and local processor straps
`timescale 1ns/1ns
`default_nettype none

// ========================================
// reset and health pins follow the sequence's requests one edge later; straps pass straight through
module brsc_partner (
	// clock and reset
	input  wire logic       ref_clk_in,
	input  wire logic       rst_in,
	// requests from the test sequence
	input  wire logic       pci_rq_in,
	input  wire logic       loc_rq_in,
	input  wire logic       unh_rq_in,
	input  wire logic [8:0] strap_in,
	// pins toward the device
	output logic            pci_n_out,
	output logic            loc_n_out,
	output logic            unh_n_out,
	output logic [8:0]      strap_out
);
	// unset straps are zero, as the board pull-downs leave them
	assign strap_out = strap_in;
	// the modelled local side starts no transfer, so no strobe ever reaches the block

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			pci_n_out <= 1'b1;
			loc_n_out <= 1'b1;
			unh_n_out <= 1'b0;
		end else begin
			pci_n_out <= ~pci_rq_in;
			// own request only, never looped from the reset output
			loc_n_out <= ~loc_rq_in;
			unh_n_out <= unh_rq_in;
		end
	end
endmodule : brsc_partner
`default_nettype wire

// file: tb/testbench.sv
// register-level tests of the reset and strap control block
`timescale 1ns/1ns
`default_nettype none

module testbench;
	// ========================================
	// stimulus and observed signals
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        pci_rq = 1'b0;
	logic        loc_rq = 1'b0;
	logic        unh_rq = 1'b0;
	logic        claim = 1'b0;
	logic [8:0]  straps = 9'h000;
	logic [7:0]  nand_v = 8'h00;
	logic        cyc = 1'b0;
	logic        we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [31:0] wdat = 32'h0000_0000;
	logic [31:0] rdat;
	wire logic   pci_n, loc_n, unh_n, lro_n, hs_oe, oe_all, sck, sck_oe, inrst;
	wire logic   bme, arb, ee_p, dis, devsel, trdy, stop, ack, hs;
	wire logic [8:0]  sp;
	wire logic [1:0]  msm;
	wire logic [31:0] rd;
	int          err_total = 0;
	int          compares = 0;
	int          ee_cnt = 0;
	int          n;

	initial forever #5 clk = ~clk;
	always @(posedge clk) if (ee_p === 1'b1) ee_cnt++;

	brsc_partner partner (.ref_clk_in(clk), .rst_in(rst), .pci_rq_in(pci_rq),
		.loc_rq_in(loc_rq), .unh_rq_in(unh_rq), .strap_in(straps),
		.pci_n_out(pci_n), .loc_n_out(loc_n), .unh_n_out(unh_n), .strap_out(sp));

	brsc_top dut (.ref_clk_in(clk), .rst_in(rst), .ce_in(1'b1),
		.pci_reset_n_in(pci_n), .local_reset_in_n_in(loc_n), .backend_healthy_n_in(unh_n),
		.local_reset_out_n_out(lro_n), .local_reset_out_n_oe_out(),
		.hot_swap_indicator_out(hs), .hot_swap_indicator_oe_out(hs_oe),
		.outputs_enable_out(oe_all), .bus_master_strap_in(sp[8]),
		.burst_in_progress_pin_in(sp[7]), .size_bit_one_pin_in(sp[6]),
		.eeprom_enable_strap_in(sp[5]), .serial_data_in(sp[4]),
		.pci_access_disable_strap_in(sp[3]), .arbiter_enable_strap_in(sp[2]),
		.test_mode_pins_in(sp[1:0]), .nand_tree_in(nand_v), .serial_clock_in(1'b0),
		.serial_clock_oe_in(1'b0), .serial_clock_out(sck), .serial_clock_oe_out(sck_oe),
		.device_in_reset_out(inrst), .bus_master_enable_bit_out(bme), .ms_mode_out(msm),
		.arbiter_enable_out(arb), .eeprom_load_start_out(ee_p),
		.pci_access_disable_out(dis), .pci_claim_in(claim), .pci_ready_in(claim),
		.devsel_out(devsel), .trdy_out(trdy), .stop_out(stop), .wb_cyc_in(cyc),
		.wb_stb_in(cyc), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hF),
		.wb_dat_in(wdat), .wb_dat_out(rd), .wb_ack_out(ack));

	// ========================================
	// shared tasks
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	task automatic wt(input int c);
		repeat (c) @(posedge clk);
	endtask : wt

	// one classic cycle; the request holds until ack is sampled
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		@(posedge clk);
		while (ack !== 1'b1) begin
			@(posedge clk);
		end
		rdat = rd;
		cyc <= 1'b0;
	endtask : wb

	task automatic stop_test;
		if (err_total == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : stop_test

	initial begin
		wt(20000);
		err_total++;
		stop_test();
	end

	// ========================================
	// test sequence
	initial begin
		straps <= 9'h1AC;
		wt(8);
		rst <= 1'b0;
		wt(12);
		check("bme", bme, 1);
		check("mode", msm, 2);
		check("arb", arb, 1);
		check("dis", dis, 1);
		check("eeprom", ee_cnt, 1);
		wb(0, 8'h08, 0);
		check("status", rdat, 32'h0000_000E);
		claim <= 1'b1;
		wt(3);
		check("stop", stop, 1);
		check("trdy", trdy, 0);
		wb(1, 8'h04, 32'h0000_0002);
		wt(2);
		check("trdy", trdy, 1);
		check("dis", dis, 0);
		wb(1, 8'h0C, 32'hFFFF_FFFF);
		wb(0, 8'h0C, 0);
		check("unmapped", rdat, 0);
		wb(1, 8'h00, 1);
		wt(2);
		check("lro", lro_n, 0);
		check("inrst", inrst, 0);
		wb(1, 8'h00, 0);
		wt(2);
		check("lro", lro_n, 1);
		wb(1, 8'h00, 1);
		loc_rq <= 1'b1;
		wt(6);
		check("lro", lro_n, 1);
		check("devsel", devsel, 0);
		check("inrst", inrst, 1);
		loc_rq <= 1'b0;
		wt(6);
		wb(0, 8'h00, 0);
		check("swbit", rdat, 0);
		check("devsel", devsel, 1);
		wb(1, 8'h00, 1);
		pci_rq <= 1'b1;
		wt(6);
		check("lro", lro_n, 0);
		pci_rq <= 1'b0;
		wt(6);
		check("lro", lro_n, 1);
		wb(0, 8'h00, 0);
		check("swbit", rdat, 0);
		unh_rq <= 1'b1;
		wt(6);
		check("hs_oe", hs_oe, 1);
		check("hs", hs, 0);
		check("oe", oe_all, 0);
		unh_rq <= 1'b0;
		straps <= 9'h1AD;
		pci_rq <= 1'b1;
		wt(6);
		pci_rq <= 1'b0;
		wt(8);
		nand_v <= 8'hFF;
		wt(3);
		check("sck", sck, 0);
		check("sck_oe", sck_oe, 1);
		nand_v <= 8'hFE;
		straps <= 9'h1AC;
		wt(3);
		check("sck", sck, 1);
		check("oe", oe_all, 0);
		pci_rq <= 1'b1;
		wt(6);
		pci_rq <= 1'b0;
		wt(8);
		check("oe", oe_all, 1);
		wb(1, 8'h00, 2);
		wt(2);
		check("inrst", inrst, 1);
		n = 0;
		while (lro_n === 1'b0 && n < 1100) begin
			@(posedge clk);
			n++;
		end
		// only the first low cycle passes uncounted, since the loop first tests lro_n on the second edge of wt(2); one is added back
		n = n + 1;
		check("psc", (n >= brsc_pkg::PSC_MIN_CLKS && n <= brsc_pkg::PSC_MAX_CLKS), 1);
		stop_test();
	end
endmodule : testbench
`default_nettype wire
